/* rtl/pwm_ctrl.sv */
// Four-channel PWM controller: APB register file, prescalers, interrupts, channels.
// Assumes a single mclk domain, a synchronous active-high reset and a standard APB master.
`timescale 1ns/10ps
module pwm_ctrl #(
	parameter int channels = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Waveform pins and interrupt
	output logic [channels-1:0] pwm_out,
	output logic irq
);
	logic [31:0] gmode_r, gmode_nxt, rdata_r, rdata_nxt;
	logic [channels-1:0] mask_r, mask_nxt, flags_r, flags_nxt;
	logic [10:0] cmode_r [channels];
	logic [10:0] cmode_nxt [channels];
	logic [10:0] pre_r, pre_nxt;
	logic [10:0] pre_edge;
	logic [31:0] rview;
	logic rmiss;
	logic divided_clock_a, divided_clock_b;
	logic wr, rd, err;
	logic [3:0] chan_idx;
	logic [4:0] chan_reg;
	logic in_chan;
	logic [channels-1:0] duty_wr, period_wr, run, pend, start, stop, upd_wr, tick;
	logic [15:0] duty_v [channels];
	logic [15:0] per_v [channels];
	logic [15:0] cnt_v [channels];

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign chan_idx = paddr[8:5];
	assign chan_reg = paddr[4:0];
	assign in_chan = (paddr >= pwm_pkg::chan_base) && (32'(chan_idx) < 32'(channels)) && (paddr[11:9] == 3'b001);

	// Free-running prescaler; bit k toggles every 2**k ticks, its rising point gives a tick.
	always_comb begin
		pre_nxt = pre_r + 11'h001;
	end
	assign pre_edge = pre_nxt & ~pre_r;

	always_ff @(posedge mclk) begin
		if (reset) begin
			pre_r <= 11'h000;
		end else begin
			pre_r <= pre_nxt;
		end
	end

	// Divided clocks A and B from the global mode register.
	pwm_divider div_a (
		.mclk(mclk),
		.reset(reset),
		.pre_sel(gmode_r[pwm_pkg::prea_lsb +: 4]),
		.divide(gmode_r[pwm_pkg::diva_lsb +: 8]),
		.pre_edge(pre_edge),
		.tick(divided_clock_a)
	);
	pwm_divider div_b (
		.mclk(mclk),
		.reset(reset),
		.pre_sel(gmode_r[pwm_pkg::preb_lsb +: 4]),
		.divide(gmode_r[pwm_pkg::divb_lsb +: 8]),
		.pre_edge(pre_edge),
		.tick(divided_clock_b)
	);

	generate
		for (genvar i = 0; i < channels; i++) begin : g_ch
			pwm_chan_if cif ();
			logic [3:0] sel;
			assign sel = cmode_r[i][pwm_pkg::prescale_msb:pwm_pkg::prescale_lsb];
			always_comb begin
				if (sel == 4'h0) begin
					tick[i] = 1'b1;
				end else if (sel <= pwm_pkg::max_pow2_code) begin
					tick[i] = pre_edge[sel - 4'h1];
				end else if (sel == pwm_pkg::divided_clock_a_code) begin
					tick[i] = divided_clock_a;
				end else if (sel == pwm_pkg::divided_clock_b_code) begin
					tick[i] = divided_clock_b;
				end else begin
					tick[i] = 1'b0;
				end
			end
			assign cif.tick = tick[i];
			assign cif.start = start[i];
			assign cif.stop = stop[i];
			assign cif.mode = cmode_r[i];
			assign cif.upd_wr = upd_wr[i];
			assign cif.upd_data = pwdata[15:0];
			assign run[i] = cif.run;
			assign duty_v[i] = cif.duty;
			assign per_v[i] = cif.period;
			assign cnt_v[i] = cif.count;
			assign pend[i] = cif.period_end;
			assign pwm_out[i] = cif.wave;
			assign duty_wr[i] = wr && in_chan && (32'(chan_idx) == i) && (chan_reg == pwm_pkg::chan_duty_offset);
			assign period_wr[i] = wr && in_chan && (32'(chan_idx) == i) && (chan_reg == pwm_pkg::chan_period_offset);
			assign upd_wr[i] = wr && in_chan && (32'(chan_idx) == i) && (chan_reg == pwm_pkg::chan_update_offset);
			assign start[i] = wr && (paddr == pwm_pkg::enable_offset) && pwdata[i];
			assign stop[i] = wr && (paddr == pwm_pkg::disable_offset) && pwdata[i];
			pwm_channel u_ch (
				.mclk(mclk),
				.reset(reset),
				.ch(cif.chan),
				.duty_wr(duty_wr[i]),
				.period_wr(period_wr[i]),
				.wdata(pwdata[15:0])
			);
		end
	endgenerate

	// Register writes, flags and read data.
	always_comb begin
		gmode_nxt = gmode_r;
		mask_nxt = mask_r;
		cmode_nxt = cmode_r;
		err = 1'b0;
		flags_nxt = flags_r;
		if (rd && paddr == pwm_pkg::irq_flags_offset) begin
			flags_nxt = '0;
		end
		flags_nxt = flags_nxt | pend;
		if (wr) begin
			case (paddr)
				pwm_pkg::mode_offset: gmode_nxt = pwdata & pwm_pkg::mode_write_mask;
				pwm_pkg::enable_offset, pwm_pkg::disable_offset: err = 1'b0;
				pwm_pkg::irq_set_offset: mask_nxt = mask_r | pwdata[channels-1:0];
				pwm_pkg::irq_clear_offset: mask_nxt = mask_r & ~pwdata[channels-1:0];
				default: begin
					if (in_chan && chan_reg == pwm_pkg::chan_mode_offset) begin
						cmode_nxt[chan_idx[1:0]] = pwdata[10:0];
					end else if (!(in_chan && (chan_reg == pwm_pkg::chan_duty_offset ||
						chan_reg == pwm_pkg::chan_period_offset || chan_reg == pwm_pkg::chan_update_offset))) begin
						err = 1'b1;
					end
				end
			endcase
		end
		// Read data is looked up in the setup phase and registered for the access phase.
		rview = 32'h00000000;
		rmiss = 1'b0;
		case (paddr)
			pwm_pkg::mode_offset: rview = gmode_r;
			pwm_pkg::status_offset: rview[channels-1:0] = run;
			pwm_pkg::irq_mask_offset: rview[channels-1:0] = mask_r;
			pwm_pkg::irq_flags_offset: rview[channels-1:0] = flags_r | pend;
			default: begin
				if (in_chan) begin
					case (chan_reg)
						pwm_pkg::chan_mode_offset: rview[10:0] = cmode_r[chan_idx[1:0]];
						pwm_pkg::chan_duty_offset: rview[15:0] = duty_v[chan_idx[1:0]];
						pwm_pkg::chan_period_offset: rview[15:0] = per_v[chan_idx[1:0]];
						pwm_pkg::chan_count_offset: rview[15:0] = cnt_v[chan_idx[1:0]];
						default: rmiss = 1'b1;
					endcase
				end else begin
					rmiss = 1'b1;
				end
			end
		endcase
		rdata_nxt = 32'h00000000;
		if (psel && !penable && !pwrite) begin
			rdata_nxt = rview;
		end
		if (rd && rmiss) begin
			err = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			gmode_r <= pwm_pkg::global_mode_reset;
			mask_r <= '0;
			flags_r <= '0;
			rdata_r <= 32'h00000000;
			for (int k = 0; k < channels; k++) begin
				cmode_r[k] <= pwm_pkg::chan_mode_reset;
			end
		end else begin
			gmode_r <= gmode_nxt;
			mask_r <= mask_nxt;
			flags_r <= flags_nxt;
			rdata_r <= rdata_nxt;
			cmode_r <= cmode_nxt;
		end
	end

	// Read data is captured at the end of the setup phase, so the access phase needs no wait state.
	assign prdata = rdata_r;
	assign pslverr = psel && penable && err;
	assign irq = |(flags_r & mask_r);
endmodule

/* rtl/pwm_pkg.sv */
// Package for the four-channel PWM control block: register map, fields, reset values.
// Assumes a 32-bit APB with byte addresses; each register takes one aligned word.
package pwm_pkg;
	localparam int num_channels = 4;
	localparam int counter_width = 16;
	localparam logic [11:0] mode_offset = 12'h000;
	localparam logic [11:0] enable_offset = 12'h004;
	localparam logic [11:0] disable_offset = 12'h008;
	localparam logic [11:0] status_offset = 12'h00C;
	localparam logic [11:0] irq_set_offset = 12'h010;
	localparam logic [11:0] irq_clear_offset = 12'h014;
	localparam logic [11:0] irq_mask_offset = 12'h018;
	localparam logic [11:0] irq_flags_offset = 12'h01C;
	localparam logic [11:0] chan_base = 12'h200;
	localparam logic [11:0] chan_stride = 12'h020;
	localparam logic [4:0] chan_mode_offset = 5'h00;
	localparam logic [4:0] chan_duty_offset = 5'h04;
	localparam logic [4:0] chan_period_offset = 5'h08;
	localparam logic [4:0] chan_count_offset = 5'h0C;
	localparam logic [4:0] chan_update_offset = 5'h10;
	localparam int prescale_lsb = 0;
	localparam int prescale_msb = 3;
	localparam int diva_lsb = 0;
	localparam int prea_lsb = 8;
	localparam int divb_lsb = 16;
	localparam int preb_lsb = 24;
	localparam int align_bit = 8;
	localparam int polarity_bit = 9;
	localparam int target_bit = 10;
	localparam logic [3:0] max_pow2_code = 4'hA;
	localparam logic [3:0] divided_clock_a_code = 4'hB;
	localparam logic [3:0] divided_clock_b_code = 4'hC;
	localparam logic [31:0] mode_write_mask = 32'h0FFF0FFF;
	localparam logic [10:0] chan_mode_reset = 11'h000;
	localparam logic [15:0] chan_value_reset = 16'h0000;
	localparam logic [31:0] global_mode_reset = 32'h00000000;
endpackage

/* rtl/pwm_chan_if.sv */
// Interface carrying one channel's settings and tick in, and its state out.
// Assumes the register file drives ctl and the channel drives the view.
`timescale 1ns/10ps
interface pwm_chan_if;
	logic tick;
	logic start;
	logic stop;
	logic run;
	logic [10:0] mode;
	logic [15:0] duty;
	logic [15:0] period;
	logic [15:0] count;
	logic upd_wr;
	logic [15:0] upd_data;
	logic period_end;
	logic wave;
	modport ctl (output tick, start, stop, mode, upd_wr, upd_data,
		input run, duty, period, count, period_end, wave);
	modport chan (input tick, start, stop, mode, upd_wr, upd_data,
		output run, duty, period, count, period_end, wave);
endinterface

/* rtl/pwm_channel.sv */
// One PWM channel: counter, duty/period registers with update buffer, waveform.
// Assumes a one-cycle tick per counter clock, and start/stop/upd_wr pulses from the register file.
`timescale 1ns/10ps
module pwm_channel (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Channel link
	pwm_chan_if.chan ch,
	// Direct register writes
	input wire logic duty_wr,
	input wire logic period_wr,
	input wire logic [15:0] wdata
);
	logic run_r, run_nxt, down_r, down_nxt, pend_r, pend_nxt, wave_r, wave_nxt, pe_r, pe_nxt;
	logic [15:0] cnt_r, cnt_nxt, duty_r, duty_nxt, per_r, per_nxt, upd_r, upd_nxt;
	logic bound, pstart, center, active;

	always_comb begin
		run_nxt = run_r;
		down_nxt = down_r;
		pend_nxt = pend_r;
		cnt_nxt = cnt_r;
		duty_nxt = duty_r;
		per_nxt = per_r;
		upd_nxt = upd_r;
		pe_nxt = 1'b0;
		center = ch.mode[pwm_pkg::align_bit];
		bound = 1'b0;
		pstart = 1'b0;
		if (duty_wr) begin
			duty_nxt = wdata;
		end
		if (period_wr) begin
			per_nxt = wdata;
		end
		if (ch.upd_wr) begin
			upd_nxt = ch.upd_data;
			pend_nxt = 1'b1;
		end
		if (ch.start) begin
			run_nxt = 1'b1;
			cnt_nxt = 16'h0000;
			down_nxt = 1'b0;
		end else if (ch.stop) begin
			run_nxt = 1'b0;
		end else if (run_r && ch.tick) begin
			if (!center) begin
				bound = (cnt_r >= per_r - 16'h0001) || (per_r == 16'h0000);
				cnt_nxt = bound ? 16'h0000 : cnt_r + 16'h0001;
				pstart = bound;
			end else if (!down_r) begin
				bound = (cnt_r >= per_r);
				cnt_nxt = bound ? ((cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001) : cnt_r + 16'h0001;
				down_nxt = bound;
			end else begin
				bound = (cnt_r <= 16'h0001);
				cnt_nxt = bound ? 16'h0000 : cnt_r - 16'h0001;
				down_nxt = !bound;
				pstart = bound;
			end
		end
		if (pstart) begin
			pe_nxt = 1'b1;
			if (pend_r && !ch.upd_wr) begin
				pend_nxt = 1'b0;
				if (ch.mode[pwm_pkg::target_bit]) begin
					per_nxt = upd_r;
				end else begin
					duty_nxt = upd_r;
				end
			end
		end
		active = (cnt_nxt < duty_nxt);
		wave_nxt = run_nxt ? (ch.mode[pwm_pkg::polarity_bit] ~^ active) : ch.mode[pwm_pkg::polarity_bit];
		if (!run_nxt) begin
			wave_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			run_r <= 1'b0;
			down_r <= 1'b0;
			pend_r <= 1'b0;
			wave_r <= 1'b0;
			pe_r <= 1'b0;
			cnt_r <= pwm_pkg::chan_value_reset;
			duty_r <= pwm_pkg::chan_value_reset;
			per_r <= pwm_pkg::chan_value_reset;
			upd_r <= pwm_pkg::chan_value_reset;
		end else begin
			run_r <= run_nxt;
			down_r <= down_nxt;
			pend_r <= pend_nxt;
			wave_r <= wave_nxt;
			pe_r <= pe_nxt;
			cnt_r <= cnt_nxt;
			duty_r <= duty_nxt;
			per_r <= per_nxt;
			upd_r <= upd_nxt;
		end
	end

	assign ch.run = run_r;
	assign ch.duty = duty_r;
	assign ch.period = per_r;
	assign ch.count = cnt_r;
	assign ch.period_end = pe_r;
	assign ch.wave = wave_r;
endmodule

/* rtl/pwm_divider.sv */
// Divided clock generator: picks a prescaler tap and divides it by a programmable factor.
// Assumes pre_edge holds one-cycle ticks of mclk divided by 2, 4 ... 2048.
`timescale 1ns/10ps
module pwm_divider (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Settings
	input wire logic [3:0] pre_sel,
	input wire logic [7:0] divide,
	input wire logic [10:0] pre_edge,
	// Output tick
	output logic tick
);
	logic [7:0] cnt_r, cnt_nxt;
	logic tick_r, tick_nxt, src;

	always_comb begin
		if (pre_sel == 4'h0) begin
			src = 1'b1;
		end else if (pre_sel <= pwm_pkg::max_pow2_code) begin
			src = pre_edge[pre_sel - 4'h1];
		end else begin
			src = 1'b0;
		end
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (divide == 8'h00) begin
			cnt_nxt = 8'h00;
		end else if (src) begin
			if (cnt_r + 8'h01 >= divide) begin
				cnt_nxt = 8'h00;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule

/* bench/pwm_ctrl_asserts.sv */
// Checker for the PWM controller's bus, pin and interrupt ports.
// Assumes it is bound to pwm_ctrl and sees only that module's ports.
`timescale 1ns/10ps
module pwm_ctrl_asserts #(
	parameter int channels = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic [channels-1:0] pwm_out,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_rd(a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_idle_quiet: assert property (!(psel && penable) |-> prdata == 32'h0 && !pslverr) else $error("idle bus busy");
	a_reset_quiet: assert property ($fell(reset) |-> pwm_out == '0 && !irq) else $error("outputs after reset");
	a_gap_error: assert property (psel && penable && paddr inside {[12'h020:12'h1FF]} |-> pslverr && prdata == 32'h0)
		else $error("gap access accepted");
	a_wo_read: assert property (s_rd(pwm_pkg::enable_offset) |-> pslverr && prdata == 32'h0) else $error("read of enable");
	a_mask_irq: assert property (s_rd(pwm_pkg::irq_mask_offset) ##0 prdata[channels-1:0] == '0 |=> !irq)
		else $error("irq with mask clear");
	a_status_pins: assert property (s_rd(pwm_pkg::status_offset) |=> (pwm_out & ~$past(prdata[channels-1:0])) == '0)
		else $error("disabled pin high");
	a_irq_held: assert property ($fell(irq) |-> $past(psel && penable && (pwrite ? paddr == pwm_pkg::irq_clear_offset
		: paddr == pwm_pkg::irq_flags_offset)))
		else $error("irq dropped unread");
endmodule
bind pwm_ctrl pwm_ctrl_asserts #(.channels(channels)) u_asserts (.mclk(mclk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));

/* bench/pwm_ctrl_tb_top.sv */
// Self-checking bench for the PWM controller: registers, waveforms and interrupt.
// Assumes pwm_ctrl answers APB by itself and runs on the single mclk.
`timescale 1ns/10ps
module pwm_ctrl_tb_top;
	logic mclk;
	logic reset;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] q;
	logic pready;
	logic pslverr;
	logic e;
	logic irq;
	logic [3:0] pwm_out;
	int bad_count;
	int num_checks;
	localparam logic [11:0] c0m = pwm_pkg::chan_base;
	localparam logic [11:0] c0d = c0m + {7'h00, pwm_pkg::chan_duty_offset};
	localparam logic [11:0] c0p = c0m + {7'h00, pwm_pkg::chan_period_offset};
	localparam logic [11:0] c0u = c0m + {7'h00, pwm_pkg::chan_update_offset};
	pwm_ctrl #(.channels(4)) uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
		.irq(irq));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("wait", 32'(n), 32'h1);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, q, exp);
	endtask
	task automatic irq_is(input logic exp);
		@(posedge mclk);
		#1;
		check("irq", {31'h0, irq}, {31'h0, exp});
	endtask
	task automatic setup(input logic [31:0] m, input logic [31:0] d, input logic [31:0] p);
		wr(pwm_pkg::disable_offset, 32'h1);
		wr(c0m, m);
		wr(c0d, d);
		wr(c0p, p);
		wr(pwm_pkg::enable_offset, 32'h1);
	endtask
	// Counts high samples and rising edges of channel 0 over n cycles once settled.
	task automatic measure(input int n, output int hi, output int rs);
		logic s;
		logic prev;
		hi = 0;
		rs = 0;
		prev = 1'b0;
		repeat (40) @(posedge mclk);
		for (int i = 0; i <= n; i++) begin
			@(posedge mclk);
			#1;
			s = pwm_out[0];
			hi += (i < n && s === 1'b1) ? 1 : 0;
			rs += (i > 0 && s === 1'b1 && prev === 1'b0) ? 1 : 0;
			prev = s;
		end
	endtask
	task automatic t_reset();
		rdc("status", pwm_pkg::status_offset, 32'h0);
		rdc("mask", pwm_pkg::irq_mask_offset, 32'h0);
		rdc("flags", pwm_pkg::irq_flags_offset, 32'h0);
		rdc("mode", c0m, 32'h0);
		rdc("duty", c0d, 32'h0);
		rdc("gap", 12'h100, 32'h0);
		check("gap err", {31'h0, e}, 32'h1);
		rdc("wo read", pwm_pkg::enable_offset, 32'h0);
		check("wo err", {31'h0, e}, 32'h1);
	endtask
	// Ones act, zeros leave bits alone, in a set/clear/view register trio.
	task automatic t_setclr(input logic [11:0] sa, input logic [11:0] ca, input logic [11:0] va);
		logic [3:0] d [5] = '{4'h5, 4'h2, 4'h4, 4'h0, 4'hF};
		logic [3:0] x [5] = '{4'h5, 4'h7, 4'h3, 4'h3, 4'h0};
		for (int i = 0; i < 5; i++) begin
			wr(i < 2 ? sa : ca, {28'h0, d[i]});
			rdc("view", va, {28'h0, x[i]});
		end
	endtask
	task automatic t_fields();
		wr(c0d + pwm_pkg::chan_stride, 32'hFFFF1234);
		apb(1'b0, c0d + pwm_pkg::chan_stride, 32'h0);
		check("duty1", {16'h0, q[15:0]}, 32'h1234);
		wr(c0m, 32'h0000070C);
		apb(1'b0, c0m, 32'h0);
		check("mode", {21'h0, q[10:0]}, 32'h70C);
	endtask
	task automatic t_wave();
		int hi;
		int rs;
		logic [3:0] code [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hB, 4'hC};
		int n [6] = '{80, 160, 320, 640, 160, 160};
		wr(pwm_pkg::mode_offset, 32'h00020002);
		for (int i = 0; i < 6; i++) begin
			setup({20'h0, 12'h200} | {28'h0, code[i]}, 32'h3, 32'h8);
			measure(n[i], hi, rs);
			check("high", 32'(hi), 32'(n[i] * 3 / 8));
		end
		setup(32'h0, 32'h3, 32'h8);
		measure(80, hi, rs);
		check("low pol", 32'(hi), 32'd50);
		setup(32'h300, 32'h3, 32'h8);
		measure(160, hi, rs);
		check("centre", 32'(rs), 32'd10);
		setup(32'h200, 32'h3, 32'h8);
		wr(c0m, 32'h600);
		wr(c0u, 32'h4);
		measure(40, hi, rs);
		check("upd per", 32'(hi), 32'd30);
		wr(c0m, 32'h200);
		wr(c0u, 32'h1);
		measure(40, hi, rs);
		check("upd duty", 32'(hi), 32'd10);
	endtask
	task automatic t_irq();
		wr(pwm_pkg::disable_offset, 32'hF);
		apb(1'b0, pwm_pkg::irq_flags_offset, 32'h0);
		setup(32'h200, 32'h3, 32'h8);
		repeat (20) @(posedge mclk);
		irq_is(1'b0);
		wr(pwm_pkg::disable_offset, 32'h1);
		rdc("flags", pwm_pkg::irq_flags_offset, 32'h1);
		rdc("flags", pwm_pkg::irq_flags_offset, 32'h0);
		setup(32'h200, 32'h3, 32'h8);
		repeat (20) @(posedge mclk);
		wr(pwm_pkg::disable_offset, 32'h1);
		wr(pwm_pkg::irq_set_offset, 32'h1);
		repeat (30) @(posedge mclk);
		irq_is(1'b1);
		rdc("flags", pwm_pkg::irq_flags_offset, 32'h1);
		irq_is(1'b0);
	endtask
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		bad_count = 0;
		num_checks = 0;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_setclr(pwm_pkg::enable_offset, pwm_pkg::disable_offset, pwm_pkg::status_offset);
		t_setclr(pwm_pkg::irq_set_offset, pwm_pkg::irq_clear_offset, pwm_pkg::irq_mask_offset);
		t_fields();
		t_wave();
		t_irq();
		conclude();
	end
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
endmodule
